// ### hce_cipher.v
`timescale 1ns/1ps
`default_nettype none
`include "hce_regs.vh"

module hce_cipher (
    input wire i_mclk,
    input wire i_srst,
    input wire i_ce,
    input wire i_start,
    input wire [31:0] i_block,
    input wire [63:0] i_key,
    output reg [31:0] o_block,
    output reg o_done
);
    localparam [31:0] NLF = `HCE_NLF_TABLE;
    reg [31:0] blk_reg;
    reg [63:0] key_reg;
    reg [9:0] round_reg;
    reg busy_reg;
    wire [4:0] nlf_sel = {blk_reg[31], blk_reg[26], blk_reg[20], blk_reg[9], blk_reg[1]};
    wire fb = blk_reg[0] ^ blk_reg[16] ^ NLF[nlf_sel] ^ key_reg[0];

    // one round per clock: small area traded for a long encrypt time
    always @(posedge i_mclk) begin
        if (i_srst) begin
            blk_reg <= 32'h0;
            key_reg <= 64'h0;
            round_reg <= 10'h0;
            busy_reg <= 1'b0;
            o_block <= 32'h0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_start) begin
                blk_reg <= i_block;
                key_reg <= i_key;
                round_reg <= 10'h0;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                blk_reg <= {fb, blk_reg[31:1]};
                key_reg <= {key_reg[0], key_reg[63:1]};
                round_reg <= round_reg + 10'h1;
                if (round_reg == `HCE_CIPHER_ROUNDS - 10'h1) begin
                    busy_reg <= 1'b0;
                    o_done <= 1'b1;
                    o_block <= {fb, blk_reg[31:1]};
                end
            end
        end
    end
endmodule // hce_cipher

`default_nettype wire

// ### hce_encoder.v
`timescale 1ns/1ps
`default_nettype none
`include "hce_regs.vh"

module hce_encoder #(
    parameter [31:0] DEBOUNCE_CYC = `HCE_DEBOUNCE_CYC,
    parameter [31:0] TE_SLOW_CYC = `HCE_TE_SLOW_CYC,
    parameter [31:0] TE_FAST_CYC = `HCE_TE_FAST_CYC,
    parameter [31:0] TIMEOUT_CYC = `HCE_TIMEOUT_CYC
) (
    input wire i_mclk,
    input wire i_srst,
    input wire i_ce,
    input wire i_button_in_a,
    input wire i_button_in_b,
    input wire i_button_in_c_prog_clock,
    input wire i_prog_mode,
    input wire i_data_in,
    input wire i_low_batt,
    output reg o_data_out,
    output reg o_data_oe_n,
    output reg o_tx_active
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DEBOUNCE = 3'h1;
    localparam [2:0] ST_SAMPLE = 3'h2;
    localparam [2:0] ST_ENCRYPT = 3'h3;
    localparam [2:0] ST_LOAD = 3'h4;
    localparam [2:0] ST_SEND = 3'h5;
    localparam [2:0] ST_GUARD = 3'h6;
    localparam [2:0] ST_PROG = 3'h7;

    // function code: buttons a..c on bits 0..2, bit 3 forced or mirrors c
    function [3:0] func_code;
        input [2:0] btn;
        input force3;
        begin
            func_code = {force3 | btn[2], btn};
        end
    endfunction

    // the seed goes out only when every button is down
    function is_seed;
        input [2:0] btn;
        begin
            is_seed = &btn;
        end
    endfunction

    // pins are asynchronous to i_mclk
    wire [5:0] pin_raw = {i_low_batt, i_data_in, i_prog_mode, i_button_in_c_prog_clock,
        i_button_in_b, i_button_in_a};
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;

    always @(posedge i_mclk) begin
        if (i_srst) begin
            sync1_reg <= 6'h0;
            sync2_reg <= 6'h0;
        end else if (i_ce) begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    wire [2:0] btn = sync2_reg[2:0];
    wire prog_mode = sync2_reg[3];
    wire prog_din = sync2_reg[4];
    wire low_batt = sync2_reg[5];

    // non-volatile parameter store, no reset on purpose
    reg [15:0] store_mem [0:11];

    wire [63:0] cipher_key = {store_mem[`HCE_WORD_KEY3], store_mem[`HCE_WORD_KEY2],
        store_mem[`HCE_WORD_KEY1], store_mem[`HCE_WORD_KEY0]};
    wire [15:0] opt = store_mem[`HCE_WORD_OPTION];
    wire [31:0] serial = {store_mem[`HCE_WORD_SERIAL_HIGH], store_mem[`HCE_WORD_SERIAL_LOW]};
    wire [31:0] seed = {store_mem[`HCE_WORD_SEED_HIGH], store_mem[`HCE_WORD_SEED_LOW]};
    wire [11:0] check = store_mem[`HCE_WORD_CHECK_VALUE][`HCE_CHECK_VALUE_MSB:0];
    wire [15:0] next_count = store_mem[`HCE_WORD_HOP_COUNTER] + 16'h1;

    wire bit_rate_select = opt[`HCE_OPT_BIT_RATE_SELECT];
    wire min_four_frames = opt[`HCE_OPT_MIN_FOUR_FRAMES];
    wire lead_pulse_enable = opt[`HCE_OPT_LEAD_PULSE_ENABLE];
    wire func_bit3_force = opt[`HCE_OPT_FUNC_BIT3_FORCE];
    wire long_serial_enable = opt[`HCE_OPT_LONG_SERIAL_ENABLE];
    wire [31:0] te_cyc = bit_rate_select ? TE_FAST_CYC : TE_SLOW_CYC;

    reg [2:0] state_reg;
    reg [31:0] cnt_reg;
    reg [31:0] tmo_reg;
    reg [6:0] bit_left_reg;
    reg [66:0] shift_reg;
    reg [2:0] btn_latch_reg;
    reg [3:0] func_reg;
    reg low_batt_reg;
    reg [31:0] hop_reg;
    reg [31:0] plain_reg;
    reg cph_start_reg;
    reg [2:0] frames_reg;
    reg seed_reg;
    reg c_prev_reg;
    reg [15:0] prog_shift_reg;
    reg [3:0] prog_bit_reg;
    reg [3:0] prog_addr_reg;
    reg verify_reg;
    reg shutoff_reg;

    wire [31:0] cph_out;
    wire cph_done;

    hce_cipher u_cipher (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_start(cph_start_reg),
        .i_block(plain_reg),
        .i_key(cipher_key),
        .o_block(cph_out),
        .o_done(cph_done)
    );

    wire new_press = |(btn & ~btn_latch_reg);
    wire timed_out = (tmo_reg >= TIMEOUT_CYC);
    wire cell_end = (cnt_reg >= te_cyc - 32'h1);
    wire prog_rise = btn[2] & ~c_prev_reg;
    wire [15:0] prog_word = {prog_din, prog_shift_reg[15:1]};
    wire prog_word_done = prog_rise & ~verify_reg & (prog_bit_reg == 4'hf);

    // fixed part: status, then serial with or without function code on top
    wire [31:0] fixed_part = long_serial_enable ? serial : {func_reg, serial[27:0]};
    wire [65:0] code_word = {1'b0, low_batt_reg, fixed_part, hop_reg};
    wire lead_first = lead_pulse_enable & (frames_reg == 3'h0);
    wire more_frames = min_four_frames & (frames_reg < `HCE_MIN_FRAMES);

    // single write port: programmer words or the counter write-back
    // held off during reset so a reset in the sample cycle never bumps the counter
    wire mem_we = i_ce & ~i_srst & ((state_reg == ST_SAMPLE) | ((state_reg == ST_PROG) & prog_word_done));
    wire [3:0] mem_addr = (state_reg == ST_SAMPLE) ? `HCE_WORD_HOP_COUNTER : prog_addr_reg;
    wire [15:0] mem_wdata = (state_reg == ST_SAMPLE) ? next_count :
        (prog_addr_reg == `HCE_WORD_UNUSED) ? `HCE_UNUSED_WORD_VALUE : prog_word;

    always @(posedge i_mclk) begin
        if (mem_we) begin
            store_mem[mem_addr] <= mem_wdata;
        end
    end

    always @(posedge i_mclk) begin
        if (i_srst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 32'h0;
            tmo_reg <= 32'h0;
            bit_left_reg <= 7'h0;
            shift_reg <= 67'h0;
            btn_latch_reg <= 3'h0;
            func_reg <= 4'h0;
            low_batt_reg <= 1'b0;
            hop_reg <= 32'h0;
            plain_reg <= 32'h0;
            cph_start_reg <= 1'b0;
            frames_reg <= 3'h0;
            seed_reg <= 1'b0;
            c_prev_reg <= 1'b0;
            prog_shift_reg <= 16'h0;
            prog_bit_reg <= 4'h0;
            prog_addr_reg <= 4'h0;
            verify_reg <= 1'b0;
            o_data_out <= 1'b0;
            o_data_oe_n <= 1'b0;
            o_tx_active <= 1'b0;
            shutoff_reg <= 1'b0;
        end else if (i_ce) begin
            cph_start_reg <= 1'b0;
            c_prev_reg <= btn[2];
            if (state_reg != ST_IDLE && state_reg != ST_PROG && !timed_out) begin
                tmo_reg <= tmo_reg + 32'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    o_tx_active <= 1'b0;
                    o_data_out <= 1'b0;
                    o_data_oe_n <= 1'b0;
                    cnt_reg <= 32'h0;
                    tmo_reg <= 32'h0;
                    frames_reg <= 3'h0;
                    if (prog_mode) begin
                        state_reg <= ST_PROG;
                        prog_bit_reg <= 4'h0;
                        prog_addr_reg <= 4'h0;
                        verify_reg <= 1'b0;
                        o_data_oe_n <= 1'b1;
                    end else if (|btn & ~shutoff_reg) begin
                        state_reg <= ST_DEBOUNCE;
                        o_tx_active <= 1'b1;
                    end
                    // a stuck button stays shut off until every button lets go
                    if (~|btn) begin
                        shutoff_reg <= 1'b0;
                    end
                end
                ST_DEBOUNCE: begin
                    // a bounce that lets go early is treated as no press
                    if (~|btn) begin
                        state_reg <= ST_IDLE;
                    end else if (cnt_reg >= DEBOUNCE_CYC - 32'h1) begin
                        state_reg <= ST_SAMPLE;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                ST_SAMPLE: begin
                    btn_latch_reg <= btn;
                    func_reg <= func_code(btn, func_bit3_force);
                    low_batt_reg <= low_batt;
                    seed_reg <= is_seed(btn);
                    frames_reg <= 3'h0;
                    plain_reg <= {func_code(btn, func_bit3_force), check, next_count};
                    if (is_seed(btn)) begin
                        hop_reg <= seed;
                        state_reg <= ST_LOAD;
                    end else begin
                        cph_start_reg <= 1'b1;
                        state_reg <= ST_ENCRYPT;
                    end
                end
                ST_ENCRYPT: begin
                    if (cph_done) begin
                        hop_reg <= cph_out;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    cnt_reg <= 32'h0;
                    // optional one-cell start pulse ahead of the first word only
                    if (lead_first) begin
                        shift_reg <= {code_word, 1'b1};
                        bit_left_reg <= `HCE_CODE_BITS + 7'h1;
                    end else begin
                        shift_reg <= {1'b0, code_word};
                        bit_left_reg <= `HCE_CODE_BITS;
                    end
                    state_reg <= ST_SEND;
                end
                ST_SEND: begin
                    // at the fast rate every second word up to the seventh is blanked, then every word from the eighth on, to cut duty cycle
                    o_data_out <= shift_reg[0] & ~(bit_rate_select & frames_reg[0]);
                    if (new_press) begin
                        state_reg <= ST_SAMPLE;
                        o_data_out <= 1'b0;
                    end else if (cell_end) begin
                        cnt_reg <= 32'h0;
                        shift_reg <= {1'b0, shift_reg[66:1]};
                        bit_left_reg <= bit_left_reg - 7'h1;
                        if (bit_left_reg == 7'h1) begin
                            state_reg <= ST_GUARD;
                            if (frames_reg != 3'h7) begin
                                frames_reg <= frames_reg + 3'h1;
                            end
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                ST_GUARD: begin
                    o_data_out <= 1'b0;
                    if (new_press) begin
                        state_reg <= ST_SAMPLE;
                    end else if (cnt_reg >= te_cyc * `HCE_GUARD_CELLS - 32'h1) begin
                        cnt_reg <= 32'h0;
                        if (((|btn) | more_frames) & ~timed_out) begin
                            state_reg <= ST_LOAD;
                        end else begin
                            state_reg <= ST_IDLE;
                            btn_latch_reg <= 3'h0;
                            shutoff_reg <= timed_out;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                ST_PROG: begin
                    if (!prog_mode) begin
                        state_reg <= ST_IDLE;
                        o_data_oe_n <= 1'b0;
                        o_data_out <= 1'b0;
                    end else if (prog_rise && !verify_reg) begin
                        // programmer drives data, sampled on clock rise
                        o_data_oe_n <= 1'b1;
                        prog_shift_reg <= prog_word;
                        prog_bit_reg <= prog_bit_reg + 4'h1;
                        if (prog_bit_reg == 4'hf) begin
                            prog_addr_reg <= prog_addr_reg + 4'h1;
                            if (prog_addr_reg == `HCE_WORD_LAST) begin
                                prog_addr_reg <= 4'h0;
                                verify_reg <= 1'b1;
                            end
                        end
                    end else if (prog_rise && verify_reg) begin
                        // read-back phase: encoder drives the stored words out
                        o_data_oe_n <= 1'b0;
                        o_data_out <= store_mem[prog_addr_reg][prog_bit_reg];
                        prog_bit_reg <= prog_bit_reg + 4'h1;
                        if (prog_bit_reg == 4'hf) begin
                            if (prog_addr_reg == `HCE_WORD_LAST) begin
                                prog_addr_reg <= 4'h0;
                            end else begin
                                prog_addr_reg <= prog_addr_reg + 4'h1;
                            end
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // hce_encoder

`default_nettype wire

// ### hce_encoder_props.sv
`timescale 1ns/1ps
`default_nettype none
module hce_encoder_props #(
    parameter [31:0] DEBOUNCE_CYC = 32'd20
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_button_in_a,
    input wire logic i_button_in_b,
    input wire logic i_button_in_c_prog_clock,
    input wire logic i_prog_mode,
    input wire logic i_data_in,
    input wire logic i_low_batt,
    input wire logic o_data_out,
    input wire logic o_data_oe_n,
    input wire logic o_tx_active
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    wire any_btn = i_button_in_a | i_button_in_b | i_button_in_c_prog_clock;
    logic [31:0] wake_cnt;

    // saturating count of cycles since wake; ce-low cycles only make it larger
    always @(posedge i_mclk) begin
        if (i_srst || !o_tx_active)
            wake_cnt <= 32'h0;
        else if (wake_cnt < DEBOUNCE_CYC)
            wake_cnt <= wake_cnt + 32'h1;
    end

    sequence s_press_held;
        (i_ce && !i_prog_mode && !o_tx_active && any_btn) [*3];
    endsequence
    sequence s_readback_still;
        (i_prog_mode && !o_data_oe_n && !i_button_in_c_prog_clock) [*5];
    endsequence

    property p_wake;
        s_press_held |-> ##[0:2] o_tx_active;
    endproperty
    property p_debounce_quiet;
        o_tx_active && o_data_out |-> wake_cnt >= DEBOUNCE_CYC;
    endproperty
    property p_prog_release;
        $rose(i_prog_mode) && !o_tx_active |-> ##[2:6] o_data_oe_n;
    endproperty
    property p_normal_drive;
        (!i_prog_mode) [*6] |-> !o_data_oe_n;
    endproperty
    property p_readback_stands;
        s_readback_still |=> $stable(o_data_out);
    endproperty
    property p_finish_low;
        $fell(o_tx_active) |-> !o_data_out && !$past(o_data_out);
    endproperty
    property p_hold_active;
        (o_tx_active && any_btn && !i_prog_mode && i_ce) [*2] |=> o_tx_active;
    endproperty
    property p_freeze;
        !i_ce |=> $stable(o_data_out) && $stable(o_tx_active) && $stable(o_data_oe_n);
    endproperty

    a_wake: assert property (p_wake) else $error("no wake after a held press");
    a_debounce_quiet: assert property (p_debounce_quiet) else $error("data before debounce ended");
    a_prog_release: assert property (p_prog_release) else $error("data pin not released in programming");
    a_normal_drive: assert property (p_normal_drive) else $error("data pin not driven in normal mode");
    a_readback_stands: assert property (p_readback_stands) else $error("read-back bit moved without clock");
    a_finish_low: assert property (p_finish_low) else $error("powered down mid cell");
    a_hold_active: assert property (p_hold_active) else $error("transmit stopped while button held");
    a_freeze: assert property (p_freeze) else $error("outputs moved with clock enable low");
endmodule // hce_encoder_props

bind hce_encoder hce_encoder_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) hce_encoder_props_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_button_in_a(i_button_in_a),
    .i_button_in_b(i_button_in_b), .i_button_in_c_prog_clock(i_button_in_c_prog_clock),
    .i_prog_mode(i_prog_mode), .i_data_in(i_data_in), .i_low_batt(i_low_batt),
    .o_data_out(o_data_out), .o_data_oe_n(o_data_oe_n), .o_tx_active(o_tx_active));
`default_nettype wire

// ### hce_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module hce_prog_model (
    input wire logic i_mclk,
    input wire logic i_data_pin,
    output var logic o_prog_mode,
    output var logic o_prog_clock,
    output var logic o_prog_data
);
    initial begin
        o_prog_mode = 1'b0;
        o_prog_clock = 1'b0;
        o_prog_data = 1'b0;
    end

    // data set while clock low and held through the high phase
    task automatic prog_bit(input logic d);
        begin
            @(posedge i_mclk);
            o_prog_data <= d;
            repeat (4) @(posedge i_mclk);
            o_prog_clock <= 1'b1;
            repeat (4) @(posedge i_mclk);
            o_prog_clock <= 1'b0;
        end
    endtask

    task automatic program_all(input logic [191:0] img, output logic [191:0] back);
        integer i;
        begin
            @(posedge i_mclk);
            o_prog_mode <= 1'b1;
            repeat (8) @(posedge i_mclk);
            for (i = 0; i < 192; i++)
                prog_bit(img[i]);
            // released line toggles so a stale level never reads as data
            for (i = 0; i < 192; i++) begin
                prog_bit(~o_prog_data);
                back[i] = i_data_pin;
            end
            o_prog_mode <= 1'b0;
            repeat (8) @(posedge i_mclk);
        end
    endtask
endmodule // hce_prog_model
`default_nettype wire

// ### hce_regs.vh
`ifndef HCE_REGS_VH
`define HCE_REGS_VH

// parameter store word addresses
`define HCE_WORD_KEY0 4'h0
`define HCE_WORD_KEY1 4'h1
`define HCE_WORD_KEY2 4'h2
`define HCE_WORD_KEY3 4'h3
`define HCE_WORD_HOP_COUNTER 4'h4
`define HCE_WORD_UNUSED 4'h5
`define HCE_WORD_SERIAL_LOW 4'h6
`define HCE_WORD_SERIAL_HIGH 4'h7
`define HCE_WORD_SEED_LOW 4'h8
`define HCE_WORD_SEED_HIGH 4'h9
`define HCE_WORD_CHECK_VALUE 4'ha
`define HCE_WORD_OPTION 4'hb
`define HCE_WORD_COUNT 4'hc
`define HCE_WORD_LAST 4'hb
`define HCE_UNUSED_WORD_VALUE 16'h0000

// option word fields
`define HCE_OPT_TRIM_LSB 0
`define HCE_OPT_TRIM_MSB 3
`define HCE_OPT_LOW_BATT_TRIP_SELECT 4
`define HCE_OPT_BIT_RATE_SELECT 5
`define HCE_OPT_MIN_FOUR_FRAMES 6
`define HCE_OPT_LEAD_PULSE_ENABLE 7
`define HCE_OPT_FUNC_BIT3_FORCE 8
`define HCE_OPT_LONG_SERIAL_ENABLE 9
`define HCE_CHECK_VALUE_MSB 11

// cipher
`define HCE_CIPHER_ROUNDS 10'd528
// nonlinear table value is arbitrary
`define HCE_NLF_TABLE 32'h5a3c96e1

// timing
`define HCE_MCLK_PERIOD_NS 20
`define HCE_DEBOUNCE_NS 4500000
`define HCE_DEBOUNCE_CYC ((`HCE_DEBOUNCE_NS + `HCE_MCLK_PERIOD_NS - 1) / `HCE_MCLK_PERIOD_NS)
`define HCE_TE_SLOW_NS 400000
`define HCE_TE_SLOW_CYC (`HCE_TE_SLOW_NS / `HCE_MCLK_PERIOD_NS)
`define HCE_TE_FAST_NS 200000
`define HCE_TE_FAST_CYC (`HCE_TE_FAST_NS / `HCE_MCLK_PERIOD_NS)
`define HCE_TIMEOUT_NS 1000000000
`define HCE_TIMEOUT_CYC (`HCE_TIMEOUT_NS / `HCE_MCLK_PERIOD_NS)
`define HCE_GUARD_CELLS 32'd10
`define HCE_MIN_FRAMES 3'd4
`define HCE_CODE_BITS 7'd66

`endif

// ### hopping_code_encoder_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module hopping_code_encoder_core_test;
    int te;
    localparam logic [31:0] SER = 32'ha5c37e19;
    localparam logic [31:0] SEED = 32'hc0de5eed;
    logic mclk, srst, ce, low_batt, data_out, data_oe_n, tx_active;
    logic prog_mode, prog_clock, prog_data;
    logic [2:0] btn;
    logic [65:0] f;
    logic [31:0] hop_a;
    int bad_count, checks;
    wire c_pin = prog_mode ? prog_clock : btn[2];
    wire data_pin = !data_oe_n ? data_out : prog_data;

    hce_encoder #(.DEBOUNCE_CYC(32'd20), .TE_SLOW_CYC(32'd8), .TE_FAST_CYC(32'd4), .TIMEOUT_CYC(32'd5000))
        hce_encoder_inst (.i_mclk(mclk), .i_srst(srst), .i_ce(ce), .i_button_in_a(btn[0]),
        .i_button_in_b(btn[1]), .i_button_in_c_prog_clock(c_pin), .i_prog_mode(prog_mode),
        .i_data_in(data_pin), .i_low_batt(low_batt), .o_data_out(data_out), .o_data_oe_n(data_oe_n),
        .o_tx_active(tx_active));
    hce_prog_model hce_prog_model_inst (.i_mclk(mclk), .i_data_pin(data_pin), .o_prog_mode(prog_mode),
        .o_prog_clock(prog_clock), .o_prog_data(prog_data));

    function automatic logic [191:0] img(input logic [15:0] opt);
        img = {opt, 16'hf123, SEED, SER, 16'hbeef, 16'h1234, 64'h0123456789abcdef};
    endfunction

    task automatic finish_test;
        begin
            if (bad_count == 0 && checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        begin
            checks++;
            if (seen !== exp) begin
                bad_count++;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task automatic wait_lead;
        integer i;
        begin
            i = 0;
            while (data_out !== 1'b1 && i < 3000) begin
                @(posedge mclk);
                i++;
            end
        end
    endtask

    // lead cell only on a fresh word; a repeat starts 11 cells and the load cycle after the last sample
    task automatic capture(input logic first, input logic rel, output logic [65:0] fr);
        integer i;
        begin
            if (first) begin
                wait_lead();
                if (rel)
                    btn <= 3'b000;
                repeat (te + te / 2) @(posedge mclk);
            end else
                repeat (11 * te + 1) @(posedge mclk);
            for (i = 0; i < 66; i++) begin
                fr[i] = data_out;
                if (i < 65)
                    repeat (te) @(posedge mclk);
            end
        end
    endtask

    task automatic wait_idle;
        integer i;
        begin
            btn <= 3'b000;
            i = 0;
            while (tx_active !== 1'b0 && i < 30 * te) begin
                @(posedge mclk);
                i++;
            end
            check(192'(tx_active), 192'(1'b0));
            repeat (4) @(posedge mclk);
        end
    endtask

    task automatic t_program(input logic [15:0] opt);
        logic [191:0] back;
        logic [191:0] exp;
        begin
            exp = img(opt);
            exp[95:80] = 16'h0000;
            hce_prog_model_inst.program_all(img(opt), back);
            check(back, exp);
            check(192'(data_oe_n), 192'(1'b0));
        end
    endtask

    task automatic t_plain;
        logic [65:0] g;
        begin
            ce <= 1'b0;
            repeat (3) @(posedge mclk);
            ce <= 1'b1;
            btn <= 3'b001;
            capture(1'b1, 1'b0, f);
            capture(1'b0, 1'b0, g);
            check(192'(g), 192'(f));
            check(192'(f[65:32]), 192'({2'b01, 4'h1, SER[27:0]}));
            hop_a = f[31:0];
            wait_idle();
        end
    endtask

    task automatic t_release;
        begin
            btn <= 3'b001;
            capture(1'b1, 1'b1, f);
            check(192'(f[63:32]), 192'({4'h1, SER[27:0]}));
            check(192'(f[31:0] !== hop_a), 192'(1'b1));
            wait_idle();
        end
    endtask

    task automatic t_abort;
        begin
            btn <= 3'b001;
            wait_lead();
            repeat (10 * te) @(posedge mclk);
            btn <= 3'b011;
            repeat (8) @(posedge mclk);
            capture(1'b1, 1'b0, f);
            check(192'(f[63:32]), 192'({4'h3, SER[27:0]}));
            wait_idle();
        end
    endtask

    task automatic t_seed;
        begin
            btn <= 3'b111;
            capture(1'b1, 1'b0, f);
            check(192'(f[31:0]), 192'(SEED));
            check(192'(f[63:32]), 192'({4'hf, SER[27:0]}));
            wait_idle();
        end
    endtask

    // fast rate, forced function bit 3, four words minimum: words 2 and 4 blanked
    task automatic t_fast;
        logic [65:0] g;
        begin
            te = 4;
            low_batt <= 1'b0;
            btn <= 3'b001;
            capture(1'b1, 1'b1, f);
            check(192'(f[65:32]), 192'({2'b00, 4'h9, SER[27:0]}));
            capture(1'b0, 1'b0, g);
            check(192'(g), 192'(66'h0));
            capture(1'b0, 1'b0, g);
            check(192'(g), 192'(f));
            capture(1'b0, 1'b0, g);
            check(192'(g), 192'(66'h0));
            wait_idle();
            te = 8;
            low_batt <= 1'b1;
        end
    endtask

    task automatic t_long;
        begin
            btn <= 3'b010;
            capture(1'b1, 1'b0, f);
            check(192'(f[63:32]), 192'(SER));
            wait_idle();
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        btn = 3'b000;
        low_batt = 1'b1;
        bad_count = 0;
        checks = 0;
        te = 8;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_program(16'h0080);
        t_plain();
        t_release();
        t_abort();
        t_seed();
        t_program(16'h01e0);
        t_fast();
        t_program(16'h0280);
        t_long();
        finish_test();
    end

    // about 19000 cycles expected; generous margin
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        finish_test();
    end
endmodule // hopping_code_encoder_core_test
`default_nettype wire
